/* verification/dsw_ctrl_bench.sv */
`timescale 1ns/10ps
module dsw_ctrl_bench;
    import dsw_pkg::*;
    logic ref_clk_in;
    logic sys_rst_in;
    dsw_wb_req_t req;
    dsw_wb_rsp_t rsp;
    logic psave;
    logic src_en;
    dsw_evt_t evt;
    dsw_evt_t e;
    logic deep, slp, wrst, rearm, hold, iorst, sink;
    logic io_seen;
    logic [15:0] rdat;
    int bad_count;
    int comparisons;

    // Source enables driven so both their states are reached
    dsw_ctrl u_dsw_ctrl (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .wb_req_in(req), .wb_rsp_out(rsp),
        .power_save_exec_in(psave), .wake_evt_in(evt), .reset_pin_en_in(src_en), .edge_pin_en_in(src_en),
        .brownout_en_in(src_en), .deep_sleep_out(deep), .sleep_out(slp), .wake_reset_out(wrst),
        .por_rearm_out(rearm), .pin_hold_out(hold), .io_reset_out(iorst), .sd_sink_out(sink));

    // Clock, 40 ns period
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic cycle; ack and data sampled on the rising edge, released right after it
    task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        req <= '{1'b1, 1'b1, we, adr, 4'h3, {16'h0000, wd}};
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        rdat = rsp.dat[15:0];
        if (rsp.ack !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [15:0] d);
        bus(1'b1, adr, d);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [15:0] exp);
        bus(1'b0, adr, 16'h0000);
        check(rdat, exp);
    endtask

    task automatic unlock();
        wr(OFS_KEY, 16'h0055);
        wr(OFS_KEY, 16'h00AA);
    endtask

    task automatic pulse_ps();
        @(posedge ref_clk_in);
        psave <= 1'b1;
        @(posedge ref_clk_in);
        psave <= 1'b0;
        @(negedge ref_clk_in);
    endtask

    // Event held long enough for the input synchroniser
    task automatic ev_pulse(input dsw_evt_t v);
        @(posedge ref_clk_in);
        evt <= v;
        repeat (4) @(posedge ref_clk_in);
        evt <= EVT_IDLE;
        repeat (4) @(negedge ref_clk_in);
    endtask

    // Waits for the wake sequence and measures it; may inject an edge inside it
    task automatic wake_seq(input logic inject);
        int n;
        int cnt;
        n = 0;
        cnt = 0;
        io_seen = 1'b0;
        e = EVT_IDLE;
        e.edge_pin = 1'b1;
        while (wrst !== 1'b1 && n < 40) begin
            @(negedge ref_clk_in);
            n++;
        end
        while (wrst === 1'b1 && cnt < 200) begin
            io_seen |= iorst;
            cnt++;
            @(posedge ref_clk_in);
            evt <= (inject && cnt > 2 && cnt < 9) ? e : EVT_IDLE;
            @(negedge ref_clk_in);
        end
        check(16'(cnt), 16'(POR_SEQ_CYC));
    endtask

    task automatic deep_run(input dsw_evt_t v, input logic [15:0] exp_wake, input logic exp_io);
        unlock();
        wr(OFS_CTRL, 16'h8000);
        pulse_ps();
        check({15'h0000, deep}, 16'h0001);
        @(posedge ref_clk_in);
        evt <= v;
        wake_seq(1'b0);
        check({15'h0000, io_seen}, {15'h0000, exp_io});
        rd(OFS_WAKE, exp_wake);
        rd(OFS_CTRL, 16'h0001);
        wr(OFS_WAKE, 16'h0000);
        wr(OFS_RSTC, 16'h0000);
        wr(OFS_CTRL, 16'h0000);
    endtask

    task automatic t_regs();
        rd(OFS_RSTC, 16'h0001);
        rd(OFS_CTRL, 16'h0000);
        rd(8'h20, 16'h0000);
        wr(OFS_CTRL, 16'h8000);
        rd(OFS_CTRL, 16'h0000);
        unlock();
        wr(OFS_CTRL, 16'hFFFF);
        rd(OFS_CTRL, 16'h8104);
        check({15'h0000, hold}, 16'h0000);
        wr(OFS_CTRL, 16'h0000);
        $display("register test done");
    endtask

    task automatic t_deep();
        wr(OFS_SDCON, 16'h8000);
        unlock();
        wr(OFS_CTRL, 16'h8104);
        pulse_ps();
        check({14'h0000, deep, slp}, 16'h0002);
        rd(OFS_RSTC, 16'h0401);
        e = EVT_IDLE;
        e.alarm = 1'b1;
        ev_pulse(e);
        check({15'h0000, deep}, 16'h0001);
        e = EVT_IDLE;
        e.discharge_pin = 1'b0;
        ev_pulse(e);
        check({15'h0000, deep}, 16'h0001);
        // Disabled sources neither wake nor record a brownout
        @(posedge ref_clk_in);
        src_en <= 1'b0;
        e = EVT_IDLE;
        e.edge_pin = 1'b1;
        e.reset_pin_n = 1'b0;
        e.bor = 1'b1;
        ev_pulse(e);
        check({14'h0000, deep, rearm}, 16'h0002);
        @(posedge ref_clk_in);
        src_en <= 1'b1;
        e = EVT_IDLE;
        e.bor = 1'b1;
        ev_pulse(e);
        check({14'h0000, deep, rearm}, 16'h0003);
        e = EVT_IDLE;
        e.fault = 1'b1;
        ev_pulse(e);
        e = EVT_IDLE;
        e.wdt = 1'b1;
        @(posedge ref_clk_in);
        evt <= e;
        wake_seq(1'b1);
        rd(OFS_WAKE, 16'h0090);
        rd(OFS_CTRL, 16'h0107);
        check({14'h0000, hold, rearm}, 16'h0002);
        rd(OFS_RSTC, 16'h0401);
        unlock();
        wr(OFS_CTRL, 16'h8107);
        rd(OFS_WAKE, 16'h0000);
        wr(OFS_CTRL, 16'h0000);
        rd(OFS_CTRL, 16'h0000);
        check({15'h0000, hold}, 16'h0000);
        wr(OFS_RSTC, 16'h0000);
        rd(OFS_RSTC, 16'h0000);
        $display("deep sleep test done");
    endtask

    task automatic t_sources();
        logic [15:0] exp;
        for (int i = 0; i < 3; i++) begin
            e = EVT_IDLE;
            case (i)
                0: begin
                    e.edge_pin = 1'b1;
                    exp = 16'h0100;
                end
                1: begin
                    e.alarm = 1'b1;
                    exp = 16'h0008;
                end
                default: begin
                    e.reset_pin_n = 1'b0;
                    exp = 16'h0004;
                end
            endcase
            deep_run(e, exp, i == 2);
        end
        $display("wake source test done");
    endtask

    task automatic t_por();
        e = EVT_IDLE;
        e.supply_por = 1'b1;
        ev_pulse(e);
        rd(OFS_WAKE, 16'h0001);
        wr(OFS_CTRL, 16'h0104);
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd(OFS_WAKE, 16'h0000);
        rd(OFS_CTRL, 16'h0000);
        rd(OFS_RSTC, 16'h0001);
        $display("power-on test done");
    endtask

    task automatic t_sleep();
        wr(OFS_SDCON, 16'h8100);
        check({15'h0000, sink}, 16'h0001);
        pulse_ps();
        check({14'h0000, deep, slp}, 16'h0001);
        e = EVT_IDLE;
        e.discharge_pin = 1'b0;
        ev_pulse(e);
        check({15'h0000, slp}, 16'h0000);
        rd(OFS_IRQF, 16'h0001);
        wr(OFS_IRQF, 16'h0000);
        rd(OFS_IRQF, 16'h0000);
        $display("sleep test done");
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run is about five hundred cycles; this limit of 30000 cycles is ample
    initial begin
        #1200000;
        bad_count++;
        complete_run();
    end

    initial begin
        sys_rst_in = 1'b1;
        req = '0;
        psave = 1'b0;
        src_en = 1'b1;
        evt = EVT_IDLE;
        bad_count = 0;
        comparisons = 0;
        repeat (5) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_deep();
        t_sources();
        t_por();
        t_sleep();
        complete_run();
    end
endmodule

/* verilog/dsw_ctrl.sv */
`timescale 1ns/10ps
module dsw_ctrl
    import dsw_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire dsw_wb_req_t wb_req_in,
    output dsw_wb_rsp_t wb_rsp_out,
    input wire logic power_save_exec_in,
    input wire dsw_evt_t wake_evt_in,
    input wire logic reset_pin_en_in,
    input wire logic edge_pin_en_in,
    input wire logic brownout_en_in,
    output logic deep_sleep_out,
    output logic sleep_out,
    output logic wake_reset_out,
    output logic por_rearm_out,
    output logic pin_hold_out,
    output logic io_reset_out,
    output logic sd_sink_out
);
    typedef struct packed {
        dsw_mode_t mode;
        logic arm;
        logic cal_dis;
        logic sd_dis;
        logic bor_evt;
        logic hold;
        logic [15:0] wake;
        logic ds_flag;
        logic por_flag;
        logic [1:0] unlock;
        logic sd_en;
        logic sd_sink;
        logic sd_irq;
        logic [CNT_W-1:0] cnt;
        logic io_rst;
        logic deep_o;
        logic sleep_o;
        logic wrst_o;
        logic rearm_o;
        dsw_evt_t sync1;
        dsw_evt_t sync2;
        logic ack;
        logic [31:0] rdat;
    } dsw_state_t;

    dsw_state_t s;
    dsw_state_t n;

    // Merge a bus write into a 16-bit register by byte lane
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    dsw_evt_t ev;
    logic acc;
    logic wr;
    logic wk_rst;
    logic wk_edge;
    logic wk_cal;
    logic wk_sd;
    logic any_wake;
    logic [15:0] ctrl_rd;
    logic [15:0] rstc_rd;
    logic [15:0] sdcon_rd;
    logic [15:0] wv;

    // Wake qualification from synchronised events
    assign ev = s.sync2;
    assign acc = wb_req_in.cyc & wb_req_in.stb & ~s.ack;
    assign wr = acc & wb_req_in.we;
    assign wk_rst = reset_pin_en_in & ~ev.reset_pin_n; // R18
    assign wk_edge = edge_pin_en_in & ev.edge_pin; // R15
    assign wk_cal = ~s.cal_dis & ev.alarm; // R6
    assign wk_sd = ~s.sd_dis & s.sd_en & ~ev.discharge_pin; // R7
    assign any_wake = wk_rst | wk_edge | wk_cal | wk_sd | ev.wdt | ev.supply_por;

    // Readback views, unused bits forced low
    always_comb begin
        ctrl_rd = '0; // R27
        ctrl_rd[CTRL_ARM_B] = s.arm;
        ctrl_rd[CTRL_CALDIS_B] = s.cal_dis;
        ctrl_rd[CTRL_SDDIS_B] = s.sd_dis;
        ctrl_rd[CTRL_BOR_B] = s.bor_evt;
        ctrl_rd[CTRL_HOLD_B] = s.hold;
        rstc_rd = '0;
        rstc_rd[RSTC_DS_B] = s.ds_flag;
        rstc_rd[RSTC_POR_B] = s.por_flag;
        sdcon_rd = '0;
        sdcon_rd[SD_EN_B] = s.sd_en;
        sdcon_rd[SD_SINK_B] = s.sd_sink;
    end

    // Next state: bus writes first, hardware sets after so they win
    always_comb begin
        n = s;
        wv = '0;
        n.sync1 = wake_evt_in;
        n.sync2 = s.sync1;
        n.ack = acc;
        n.rdat = '0;
        if (acc && !wb_req_in.we) begin
            if (wb_req_in.adr == OFS_CTRL) begin
                n.rdat = {16'h0000, ctrl_rd};
            end else if (wb_req_in.adr == OFS_WAKE) begin
                n.rdat = {16'h0000, s.wake & WAKE_MASK}; // R27
            end else if (wb_req_in.adr == OFS_RSTC) begin
                n.rdat = {16'h0000, rstc_rd};
            end else if (wb_req_in.adr == OFS_SDCON) begin
                n.rdat = {16'h0000, sdcon_rd};
            end else if (wb_req_in.adr == OFS_IRQF) begin
                n.rdat[IRQF_SD_B] = s.sd_irq;
            end
        end
        if (wr) begin
            if (wb_req_in.adr == OFS_CTRL) begin
                wv = wmerge(ctrl_rd, wb_req_in.dat, wb_req_in.sel);
                n.unlock = UNL_IDLE;
                if (!wv[CTRL_ARM_B]) begin
                    n.arm = 1'b0;
                end else if (s.unlock == UNL_OPEN) begin
                    n.arm = 1'b1; // R23
                    if (!s.arm) begin
                        n.wake = '0; // R12
                    end
                end
                n.cal_dis = wv[CTRL_CALDIS_B];
                n.sd_dis = wv[CTRL_SDDIS_B];
                n.bor_evt = s.bor_evt & wv[CTRL_BOR_B]; // R8
                n.hold = s.hold & wv[CTRL_HOLD_B]; // R26
            end else if (wb_req_in.adr == OFS_WAKE) begin
                wv = wmerge(s.wake, wb_req_in.dat, wb_req_in.sel);
                n.wake = s.wake & wv & WAKE_MASK;
            end else if (wb_req_in.adr == OFS_KEY && wb_req_in.sel[0]) begin
                // Any stray key value drops back to idle
                if (wb_req_in.dat[7:0] == KEY_FIRST) begin
                    n.unlock = UNL_HALF;
                end else if (wb_req_in.dat[7:0] == KEY_SECOND && s.unlock == UNL_HALF) begin
                    n.unlock = UNL_OPEN; // R23
                end else begin
                    n.unlock = UNL_IDLE;
                end
            end else if (wb_req_in.adr == OFS_RSTC) begin
                wv = wmerge(rstc_rd, wb_req_in.dat, wb_req_in.sel);
                n.ds_flag = s.ds_flag & wv[RSTC_DS_B];
                n.por_flag = s.por_flag & wv[RSTC_POR_B];
            end else if (wb_req_in.adr == OFS_SDCON) begin
                wv = wmerge(sdcon_rd, wb_req_in.dat, wb_req_in.sel);
                n.sd_en = wv[SD_EN_B];
                n.sd_sink = wv[SD_SINK_B];
            end else if (wb_req_in.adr == OFS_IRQF) begin
                n.sd_irq = s.sd_irq & wb_req_in.dat[IRQF_SD_B];
            end
        end
        // Power state sequencer
        case (s.mode)
            ST_RUN: begin
                if (ev.supply_por) begin
                    n.wake[WAKE_POR_B] = 1'b1; // R14
                end
                if (power_save_exec_in) begin
                    if (s.arm) begin
                        n.mode = ST_DEEP; // R4
                        n.ds_flag = 1'b1; // R1
                        n.deep_o = 1'b1;
                    end else begin
                        n.mode = ST_SLEEP; // R4
                        n.sleep_o = 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                if (ev.supply_por) begin
                    n.wake[WAKE_POR_B] = 1'b1; // R14
                end
                if (s.sd_en && !ev.discharge_pin) begin
                    n.mode = ST_RUN; // R20
                    n.sleep_o = 1'b0;
                    n.sd_irq = 1'b1; // R21
                end
            end
            ST_DEEP: begin
                // Brownout sets its flag and re-arms the supply detector, but never wakes
                if (ev.bor && brownout_en_in) begin
                    n.bor_evt = 1'b1; // R8
                    n.rearm_o = 1'b1; // R9
                end
                if (ev.fault) begin
                    n.wake[WAKE_FLT_B] = 1'b1; // R16
                end
                if (any_wake) begin
                    n.mode = ST_WAKE;
                    // Build on the written value so a same-cycle clear is kept
                    n.wake[WAKE_EDGE_B] = n.wake[WAKE_EDGE_B] | wk_edge; // R15
                    n.wake[WAKE_WDT_B] = n.wake[WAKE_WDT_B] | ev.wdt; // R17
                    n.wake[WAKE_CAL_B] = n.wake[WAKE_CAL_B] | wk_cal; // R17
                    n.wake[WAKE_RST_B] = n.wake[WAKE_RST_B] | wk_rst; // R18
                    n.wake[WAKE_POR_B] = n.wake[WAKE_POR_B] | ev.supply_por; // R13
                    n.arm = 1'b0; // R5
                    n.hold = 1'b1; // R10
                    n.por_flag = 1'b1;
                    n.deep_o = 1'b0;
                    n.wrst_o = 1'b1;
                    n.rearm_o = 1'b0;
                    n.io_rst = wk_rst; // R25
                    n.cnt = '0;
                end
            end
            ST_WAKE: begin
                // Wake events here are dropped until the sequence ends
                n.cnt = s.cnt + CNT_W'(1); // R24
                if (s.cnt == POR_SEQ_CYC - CNT_W'(1)) begin
                    n.mode = ST_RUN;
                    n.wrst_o = 1'b0;
                    n.io_rst = 1'b0;
                end
            end
            default: begin
                n.mode = ST_RUN;
            end
        endcase
    end

    // Only a true power-on reset clears any of this state
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s <= '0; // R3 R11
            s.por_flag <= POR_FLAG_RST;
            s.sync1 <= EVT_IDLE;
            s.sync2 <= EVT_IDLE;
        end else begin
            s <= n;
        end
    end

    // Every output straight from the state register
    assign wb_rsp_out.ack = s.ack;
    assign wb_rsp_out.dat = s.rdat;
    assign deep_sleep_out = s.deep_o;
    assign sleep_out = s.sleep_o;
    assign wake_reset_out = s.wrst_o;
    assign por_rearm_out = s.rearm_o;
    assign pin_hold_out = s.hold; // R10
    assign io_reset_out = s.io_rst; // R25
    assign sd_sink_out = s.sd_sink;

    localparam int SEQ_HOLD = int'(POR_SEQ_CYC) - 1;
    logic ctrl_wr;
    assign ctrl_wr = wr && wb_req_in.adr == OFS_CTRL && wb_req_in.sel[1];

    AST_ENTER_FLAG: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R1
        s.mode == ST_RUN && power_save_exec_in && s.arm |=> s.ds_flag && deep_sleep_out ##1 s.ds_flag)
        else $error("deep sleep entry did not set status flag");
    AST_NORMAL_SLEEP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R4
        s.mode == ST_RUN && power_save_exec_in && !s.arm |=> s.mode == ST_SLEEP && sleep_out && !deep_sleep_out)
        else $error("unarmed power save did not enter normal sleep");
    AST_WAKE_DISARM: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R5
        s.mode == ST_DEEP && any_wake |=> !s.arm && pin_hold_out && wake_reset_out)
        else $error("deep sleep wake left arm bit set");
    AST_CAL_BLOCKED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R6
        s.mode == ST_DEEP && s.cal_dis && !wr |=> s.wake[WAKE_CAL_B] == $past(s.wake[WAKE_CAL_B]))
        else $error("disabled calendar alarm recorded a wake");
    AST_BOR_NO_WAKE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R9
        s.mode == ST_DEEP && !any_wake && ev.bor && brownout_en_in |=> s.mode == ST_DEEP && s.bor_evt && por_rearm_out)
        else $error("brownout left deep sleep or was not recorded");
    AST_ARM_CLEARS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R12
        $rose(s.arm) |-> s.wake[15:1] == 15'h0000)
        else $error("setting arm did not clear wake sources");
    AST_UNLOCK_NEEDED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R23
        ctrl_wr && !s.arm && s.unlock != UNL_OPEN |=> !s.arm)
        else $error("arm set without unlock sequence");
    AST_SEQ_IGNORED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R24
        s.mode == ST_WAKE && !wr |=> $stable(s.wake))
        else $error("event recorded during power-on sequence");
    AST_SD_WAKE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R21
        s.mode == ST_SLEEP && s.sd_en && !ev.discharge_pin |=> s.mode == ST_RUN && s.sd_irq && !sleep_out)
        else $error("discharge wake missed or flag not set");
    AST_HOLD_SW: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R26
        !s.hold && s.mode != ST_DEEP |=> !s.hold)
        else $error("pin hold set outside deep sleep wake");
    AST_SEQ_LEN: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R24
        $rose(wake_reset_out) |-> ##SEQ_HOLD wake_reset_out ##1 !wake_reset_out)
        else $error("power-on sequence length wrong");
endmodule

/* verilog/dsw_pkg.sv */
// Operation
// R1 - Deep sleep entry sets sticky status flag
// R2 - Software decodes reset cause from two flags
// R3 - True power-on reset clears all logic
// R4 - Arm bit selects deep or normal sleep
// R5 - Deep sleep wake clears arm bit
// R6 - Calendar wake disable blocks alarm wake
// R7 - Discharge wake disable blocks its wake
// R8 - Brownout bit set only by active detector
// R9 - Deep brownout never wakes, only re-arms
// R10 - Pin hold keeps pins at entry state
// R11 - Control bits survive deep sleep exit
// R12 - Setting arm clears wake source bits
// R13 - Wake bits survive exit reset
// R14 - Supply power-on flag settable any time
// R15 - Edge pin assertion sets edge flag
// R16 - Fault in deep sleep sets fault flag
// R17 - Watchdog and alarm set their flags
// R18 - Enabled reset pin sets its flag
// R19 - Software clears flags, then pin hold
// R20 - Discharge pin low wakes normal sleep
// R21 - Discharge wake sets interrupt flag
// R22 - Software charges pin, then enables module
// R23 - Arm needs 55h then AAh key
// R24 - Events during power-on sequence ignored
// R25 - Reset pin wake resets pins, keeps state
// R26 - Pin hold cleared only by software
// R27 - Unused bits read zero
package dsw_pkg;
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] OFS_WAKE = 8'h04;
    localparam logic [ADR_W-1:0] OFS_KEY = 8'h08;
    localparam logic [ADR_W-1:0] OFS_RSTC = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_SDCON = 8'h10;
    localparam logic [ADR_W-1:0] OFS_IRQF = 8'h14;
    // Control register fields
    localparam int CTRL_ARM_B = 15;
    localparam int CTRL_CALDIS_B = 8;
    localparam int CTRL_SDDIS_B = 2;
    localparam int CTRL_BOR_B = 1;
    localparam int CTRL_HOLD_B = 0;
    // Wake source fields
    localparam int WAKE_EDGE_B = 8;
    localparam int WAKE_FLT_B = 7;
    localparam int WAKE_WDT_B = 4;
    localparam int WAKE_CAL_B = 3;
    localparam int WAKE_RST_B = 2;
    localparam int WAKE_POR_B = 0;
    localparam logic [15:0] WAKE_MASK = 16'h019D;
    // Reset control, discharge control, interrupt flag fields
    localparam int RSTC_DS_B = 10;
    localparam int RSTC_POR_B = 0;
    localparam int SD_EN_B = 15;
    localparam int SD_SINK_B = 8;
    localparam int IRQF_SD_B = 0;
    // Unlock keys and states
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [1:0] UNL_IDLE = 2'h0;
    localparam logic [1:0] UNL_HALF = 2'h1;
    localparam logic [1:0] UNL_OPEN = 2'h2;
    // Power-on sequence after deep sleep exit
    localparam int CLK_NS = 40;
    localparam int POR_SEQ_NS = 2000;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] POR_SEQ_CYC = CNT_W'((POR_SEQ_NS + CLK_NS - 1) / CLK_NS);
    localparam logic POR_FLAG_RST = 1'b1;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_DEEP, ST_WAKE} dsw_mode_t;
    typedef struct packed {
        logic reset_pin_n;
        logic edge_pin;
        logic discharge_pin;
        logic wdt;
        logic alarm;
        logic bor;
        logic supply_por;
        logic fault;
    } dsw_evt_t;
    localparam dsw_evt_t EVT_IDLE = 8'hA0;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } dsw_wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } dsw_wb_rsp_t;
endpackage
